// File: tws_pkg.sv
// Shared constants and types of the two-wire memory slave
package tws_pkg;
  // ==========================================================
  // Timing
  localparam int CLOCK_KHZ     = 20000;
  localparam int WRITE_TIME_US = 5000;
  localparam int WRITE_CYCLES  = (WRITE_TIME_US * CLOCK_KHZ) / 1000;

  // ==========================================================
  // Array geometry
  localparam int ADDR_W     = 12;
  localparam int OFS_W      = 5;
  localparam int PAGE_W     = ADDR_W - OFS_W;
  localparam int PAGE_BYTES = 32;
  localparam int BYTE_W     = 8;
  localparam logic [1:0] PROT_QUAD = 2'h3;

  // ==========================================================
  // Slave address byte and sequence
  localparam logic [3:0] DEV_TYPE_DEFAULT = 4'h5; // Arbitrary value
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [1:0] IDX_DEV   = 2'h0;
  localparam logic [1:0] IDX_AH    = 2'h1;
  localparam logic [1:0] IDX_AL    = 2'h2;
  localparam logic [1:0] IDX_DATA  = 2'h3;
  localparam logic [4:0] SYNC_RST  = 5'h1F;

  // ==========================================================
  // Bus-side states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RX   = 3'h1,
    ST_ACK  = 3'h3,
    ST_TX   = 3'h2,
    ST_RACK = 3'h6
  } tws_state_t;
endpackage

// File: tws_if.sv
// Internal carriers: synchronised line events and array access
`timescale 1ns/1ns
interface tws_line_if;
  logic       scl;
  logic       sda;
  logic       scl_rise;
  logic       scl_fall;
  logic       start;
  logic       stop;
  logic       wp;
  logic [2:0] sel;
  modport src (output scl, sda, scl_rise, scl_fall, start, stop, wp, sel);
  modport dst (input  scl, sda, scl_rise, scl_fall, start, stop, wp, sel);
endinterface // tws_line_if

interface tws_nvm_if;
  logic        load;
  logic        commit;
  logic        busy;
  logic        wp;
  logic [11:0] wr_addr;
  logic [11:0] rd_addr;
  logic [7:0]  wr_data;
  logic [7:0]  rd_data;
  modport ctl (output load, commit, wp, wr_addr, rd_addr, wr_data, input busy, rd_data);
  modport mem (input  load, commit, wp, wr_addr, rd_addr, wr_data, output busy, rd_data);
endinterface // tws_nvm_if

// File: tws_sync.sv
// Pin synchronisers and start, stop and clock-edge detection
`timescale 1ns/1ns
module tws_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Raw pins: scl, sda, wp, sel[2:0] packed as {sel, wp, sda, scl}
  input  wire logic [5:0] pins,
  // Events to the controller
  tws_line_if.src   line
);
  import tws_pkg::*;

  typedef struct packed {
    logic [5:0] meta;
    logic [5:0] sync;
    logic [1:0] prev;
  } tws_sync_t;

  tws_sync_t sync_ff;
  tws_sync_t nxt_sync;

  // ==========================================================
  // Two stages per pin; only the second stage feeds logic
  always_comb begin
    nxt_sync      = sync_ff;
    nxt_sync.meta = pins;
    nxt_sync.sync = sync_ff.meta;
    nxt_sync.prev = sync_ff.sync[1:0];
  end

  // Idle bus reads high, so reset to ones avoids a false start
  always_ff @(posedge clk) begin
    if (rst) begin
      sync_ff <= {1'b1, SYNC_RST, 1'b1, SYNC_RST, 2'h3};
    end else begin
      sync_ff <= nxt_sync;
    end
  end

  // ==========================================================
  // Edge and condition decode
  assign line.scl      = sync_ff.sync[0];
  assign line.sda      = sync_ff.sync[1];
  assign line.wp       = sync_ff.sync[2];
  assign line.sel      = sync_ff.sync[5:3];
  assign line.scl_rise = sync_ff.sync[0] & ~sync_ff.prev[0];
  assign line.scl_fall = ~sync_ff.sync[0] & sync_ff.prev[0];
  assign line.start    = sync_ff.sync[0] & sync_ff.prev[0] & ~sync_ff.sync[1] & sync_ff.prev[1];
  assign line.stop     = sync_ff.sync[0] & sync_ff.prev[0] & sync_ff.sync[1] & ~sync_ff.prev[1];
endmodule // tws_sync

// File: tws_nvm.sv
// Memory array, page latch and self-timed programming cycle
`timescale 1ns/1ns
module tws_nvm #(
  parameter int WRITE_CYCLES = tws_pkg::WRITE_CYCLES
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Access from the controller
  tws_nvm_if.mem    nvm
);
  import tws_pkg::*;

  localparam int TW = $clog2(WRITE_CYCLES + 1);

  logic [BYTE_W-1:0]     mem_ff  [0:(1 << ADDR_W) - 1];
  logic [BYTE_W-1:0]     page_ff [0:PAGE_BYTES - 1];
  logic [PAGE_BYTES-1:0] valid_ff;
  logic [PAGE_W-1:0]     page_no_ff;
  logic [TW-1:0]         timer_ff;
  logic                  busy_ff;
  logic                  protect;

  assign protect     = nvm.wp && (page_no_ff[PAGE_W-1:PAGE_W-2] == PROT_QUAD);
  assign nvm.busy    = busy_ff;
  assign nvm.rd_data = mem_ff[nvm.rd_addr];

  // ==========================================================
  // Bytes gather in the latch; the array changes only at the end
  // of the timed cycle, so a read during it still sees old data
  always_ff @(posedge clk) begin
    if (rst) begin
      valid_ff   <= '0;
      page_no_ff <= '0;
      timer_ff   <= '0;
      busy_ff    <= 1'b0;
    end else if (busy_ff) begin
      if (timer_ff == '0) begin
        busy_ff  <= 1'b0;
        valid_ff <= '0;
        for (int i = 0; i < PAGE_BYTES; i++) begin
          if (valid_ff[i]) begin
            mem_ff[{page_no_ff, OFS_W'(i)}] <= page_ff[i];
          end
        end
      end else begin
        timer_ff <= timer_ff - TW'(1);
      end
    end else if (nvm.commit) begin
      if (valid_ff != '0 && !protect) begin
        busy_ff  <= 1'b1;
        timer_ff <= TW'(WRITE_CYCLES - 1);
      end else begin
        valid_ff <= '0;
      end
    end else if (nvm.load) begin
      page_ff[nvm.wr_addr[OFS_W-1:0]]  <= nvm.wr_data;
      valid_ff[nvm.wr_addr[OFS_W-1:0]] <= 1'b1;
      page_no_ff                       <= nvm.wr_addr[ADDR_W-1:OFS_W];
    end
  end

  // ==========================================================
  // Checks
  busy_hold_a: assert property (@(posedge clk) disable iff (rst)
    $rose(busy_ff) |-> busy_ff [*8])
    else $error("programming cycle ended too early");
endmodule // tws_nvm

// File: tws_top.sv
// Two-wire memory slave: byte and page write, read, address match
//
// Contract
// - Data changes with clock low; high-clock changes are start or stop.
// - Start is data falling with clock high; nothing answered before one.
// - Stop is data rising with clock high; it ends any transfer.
// - Transmitter releases after eight bits; receiver pulls low on ninth.
// - Acknowledge matching address, then every byte of a write.
// - Read: send eight bits, sample acknowledge, continue or stop sending.
// - Address byte: four type bits, three select bits, direction bit.
// - Direction one is read, zero is write.
// - Mismatch gives no acknowledge and returns to standby.
// - 128 pages of 32 bytes; low five bits pick the byte.
// - Byte write: address, two address bytes, data, then stop programs.
// - While programming, inputs ignored and data line released.
// - Page write takes up to 32 bytes, programmed together after stop.
// - Loading increments the low five bits, page bits unchanged.
// - Protect pin high blocks writes to the upper quarter.
// - Programming is self-timed, about 5 ms.
// - Busy device withholds address acknowledge so the master can poll.
// - Write past the last page byte wraps to that page's first byte.
`timescale 1ns/1ns
module tws_top #(
  parameter int         WRITE_CYCLES = tws_pkg::WRITE_CYCLES,
  parameter logic [3:0] DEV_TYPE     = tws_pkg::DEV_TYPE_DEFAULT
) (
  // Clock and reset
  input  wire logic CLOCK,
  input  wire logic RST,
  // Two-wire bus
  input  wire logic SCL,
  input  wire logic SDA_I,
  output wire logic SDA_O,
  output wire logic SDA_OE,
  // Straps
  input  wire logic CHIP_SELECT_BIT0_PIN,
  input  wire logic CHIP_SELECT_BIT1_PIN,
  input  wire logic CHIP_SELECT_BIT2_PIN,
  input  wire logic WP,
  // Status
  output wire logic WRITE_BUSY
);
  import tws_pkg::*;

  typedef struct packed {
    tws_state_t      st;
    logic [3:0]      bitcnt;
    logic [7:0]      shreg;
    logic [1:0]      idx;
    logic            rw;
    logic [11:0]     addr;
    logic            sda_oe;
    logic            got_ack;
    logic            wrote;
  } tws_ctl_t;

  tws_ctl_t  ctl_ff;
  tws_ctl_t  nxt_ctl;
  logic      match;
  logic      load;
  logic      commit;

  tws_line_if line ();
  tws_nvm_if  nvm ();

  // ==========================================================
  // Submodules
  tws_sync u_sync (
    .clk  (CLOCK),
    .rst  (RST),
    .pins ({CHIP_SELECT_BIT2_PIN, CHIP_SELECT_BIT1_PIN, CHIP_SELECT_BIT0_PIN,
            WP, SDA_I, SCL}),
    .line (line.src)
  );

  tws_nvm #(
    .WRITE_CYCLES (WRITE_CYCLES)
  ) u_nvm (
    .clk (CLOCK),
    .rst (RST),
    .nvm (nvm.mem)
  );

  // ==========================================================
  // Address match
  // type and select compare
  assign match = (ctl_ff.shreg[7:4] == DEV_TYPE) && (ctl_ff.shreg[3:1] == line.sel);

  // Array access; address counter feeds both write and read paths
  assign nvm.load    = load;
  assign nvm.commit  = commit;
  assign nvm.wp      = line.wp;
  assign nvm.wr_addr = ctl_ff.addr;
  assign nvm.wr_data = ctl_ff.shreg;
  assign nvm.rd_addr = ctl_ff.addr;

  // ==========================================================
  // Bus sequencer: sample on scl rise, change drive on scl fall
  always_comb begin
    nxt_ctl = ctl_ff;
    load    = 1'b0;
    commit  = 1'b0;
    if (line.start) begin
      nxt_ctl.sda_oe = 1'b0;
      if (!nvm.busy) begin
        nxt_ctl.st     = ST_RX;
        nxt_ctl.bitcnt = 4'h0;
        nxt_ctl.idx    = IDX_DEV;
        nxt_ctl.wrote  = 1'b0;
      end
    end else if (line.stop) begin
      nxt_ctl.st     = ST_IDLE;
      nxt_ctl.sda_oe = 1'b0;
      commit         = ctl_ff.wrote;
      nxt_ctl.wrote  = 1'b0;
    end else begin
      case (ctl_ff.st)
        ST_RX: begin
          if (line.scl_rise && ctl_ff.bitcnt != BYTE_BITS) begin
            nxt_ctl.shreg  = {ctl_ff.shreg[6:0], line.sda};
            nxt_ctl.bitcnt = ctl_ff.bitcnt + 4'h1;
          end else if (line.scl_fall && ctl_ff.bitcnt == BYTE_BITS) begin
            nxt_ctl.bitcnt = 4'h0;
            nxt_ctl.st     = ST_ACK;
            nxt_ctl.sda_oe = 1'b1;
            case (ctl_ff.idx)
              IDX_DEV: begin
                if (match) begin
                  nxt_ctl.rw  = ctl_ff.shreg[0];
                  nxt_ctl.idx = IDX_AH;
                end else begin
                  nxt_ctl.st     = ST_IDLE;
                  nxt_ctl.sda_oe = 1'b0;
                end
              end
              IDX_AH: begin
                nxt_ctl.addr[11:8] = ctl_ff.shreg[3:0];
                nxt_ctl.idx        = IDX_AL;
              end
              IDX_AL: begin
                nxt_ctl.addr[7:0] = ctl_ff.shreg;
                nxt_ctl.idx       = IDX_DATA;
              end
              default: begin
                load          = 1'b1;
                nxt_ctl.wrote = 1'b1;
                nxt_ctl.addr[4:0] = ctl_ff.addr[4:0] + 5'h1;
              end
            endcase
          end
        end
        ST_ACK: begin
          if (line.scl_fall) begin
            if (ctl_ff.rw) begin
              nxt_ctl.st     = ST_TX;
              nxt_ctl.shreg  = nvm.rd_data;
              nxt_ctl.sda_oe = ~nvm.rd_data[7];
              nxt_ctl.bitcnt = 4'h1;
            end else begin
              nxt_ctl.st     = ST_RX;
              nxt_ctl.sda_oe = 1'b0;
            end
          end
        end
        ST_TX: begin
          if (line.scl_fall) begin
            if (ctl_ff.bitcnt == BYTE_BITS) begin
              // Release for the master's acknowledge; next byte address
              nxt_ctl.st     = ST_RACK;
              nxt_ctl.sda_oe = 1'b0;
              nxt_ctl.addr   = ctl_ff.addr + 12'h001;
            end else begin
              nxt_ctl.shreg  = {ctl_ff.shreg[6:0], 1'b0};
              nxt_ctl.sda_oe = ~ctl_ff.shreg[6];
              nxt_ctl.bitcnt = ctl_ff.bitcnt + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (line.scl_rise) begin
            nxt_ctl.got_ack = ~line.sda;
          end else if (line.scl_fall) begin
            if (ctl_ff.got_ack) begin
              nxt_ctl.st     = ST_TX;
              nxt_ctl.shreg  = nvm.rd_data;
              nxt_ctl.sda_oe = ~nvm.rd_data[7];
              nxt_ctl.bitcnt = 4'h1;
            end else begin
              nxt_ctl.st = ST_IDLE;
            end
          end
        end
        default: begin
          nxt_ctl.st     = ST_IDLE;
          nxt_ctl.sda_oe = 1'b0;
        end
      endcase
    end
  end

  // Reset drops any half-received byte; the array keeps its content
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ctl_ff <= '{st: ST_IDLE, default: '0};
    end else begin
      ctl_ff <= nxt_ctl;
    end
  end

  // ==========================================================
  // Outputs: open drain, only ever pulls low
  assign SDA_O      = 1'b0;
  assign SDA_OE     = ctl_ff.sda_oe;
  assign WRITE_BUSY = nvm.busy;

  // ==========================================================
  // Checks
  busy_released_a: assert property (@(posedge CLOCK) disable iff (RST)
    nvm.busy |-> !SDA_OE)
    else $error("data line driven while programming");

  poll_no_ack_a: assert property (@(posedge CLOCK) disable iff (RST)
    nvm.busy && line.start |=> ctl_ff.st == ST_IDLE)
    else $error("start accepted while busy");

  idle_quiet_a: assert property (@(posedge CLOCK) disable iff (RST)
    ctl_ff.st == ST_IDLE |-> !SDA_OE)
    else $error("driving outside a frame");

  stop_idle_a: assert property (@(posedge CLOCK) disable iff (RST)
    line.stop |=> ctl_ff.st == ST_IDLE && !SDA_OE)
    else $error("stop did not end the frame");

  drive_on_fall_a: assert property (@(posedge CLOCK) disable iff (RST)
    $rose(SDA_OE) |-> $past(line.scl_fall))
    else $error("data drive changed outside clock low");

  ack_window_a: assert property (@(posedge CLOCK) disable iff (RST)
    ctl_ff.st == ST_ACK && !line.scl_fall && !line.start && !line.stop
    |=> SDA_OE && ctl_ff.st == ST_ACK)
    else $error("acknowledge not held");

  mismatch_nack_a: assert property (@(posedge CLOCK) disable iff (RST)
    ctl_ff.st == ST_RX && ctl_ff.idx == IDX_DEV && ctl_ff.bitcnt == BYTE_BITS
    && line.scl_fall && !match && !line.start && !line.stop
    |=> ctl_ff.st == ST_IDLE && !SDA_OE)
    else $error("acknowledged a foreign address");

  page_wrap_a: assert property (@(posedge CLOCK) disable iff (RST)
    load |=> ctl_ff.addr[4:0] == $past(ctl_ff.addr[4:0]) + 5'h1
    && ctl_ff.addr[11:5] == $past(ctl_ff.addr[11:5]))
    else $error("page address moved during loading");

  read_nack_a: assert property (@(posedge CLOCK) disable iff (RST)
    ctl_ff.st == ST_RACK && line.scl_fall && !ctl_ff.got_ack
    && !line.start && !line.stop |=> ctl_ff.st == ST_IDLE)
    else $error("kept sending after nack");

  write_commit_a: assert property (@(posedge CLOCK) disable iff (RST)
    line.stop && ctl_ff.wrote && !nvm.busy |-> commit)
    else $error("stop after data did not program");

  idle_wait_a: assert property (@(posedge CLOCK) disable iff (RST)
    ctl_ff.st == ST_IDLE && !line.start |=> ctl_ff.st == ST_IDLE)
    else $error("left standby without a start");

  read_select_a: assert property (@(posedge CLOCK) disable iff (RST)
    ctl_ff.st == ST_ACK && ctl_ff.rw && line.scl_fall
    && !line.start && !line.stop |=> ctl_ff.st == ST_TX)
    else $error("read direction did not start sending");

  master_ack_free_a: assert property (@(posedge CLOCK) disable iff (RST)
    ctl_ff.st == ST_RACK |-> !SDA_OE)
    else $error("data line held during master acknowledge");

  cover_write_c: cover property (@(posedge CLOCK) disable iff (RST)
    commit ##1 nvm.busy);
  cover_read_c: cover property (@(posedge CLOCK) disable iff (RST)
    ctl_ff.st == ST_RACK && ctl_ff.got_ack && line.scl_fall);
  cover_nomatch_c: cover property (@(posedge CLOCK) disable iff (RST)
    ctl_ff.st == ST_RX && ctl_ff.idx == IDX_DEV && ctl_ff.bitcnt == BYTE_BITS
    && line.scl_fall && !match);
  cover_poll_c: cover property (@(posedge CLOCK) disable iff (RST)
    nvm.busy && line.start);
  cover_protect_c: cover property (@(posedge CLOCK) disable iff (RST)
    commit && line.wp ##1 !nvm.busy);
endmodule // tws_top

// File: tws_mst.sv
// Two-wire bus master model that drives clock and data towards the memory slave
`timescale 1ns/1ns
module tws_mst (
  // Clock
  input  wire logic clk,
  // Bus
  input  wire logic sda,
  output logic      scl,
  output logic      pull
);
  // ==========================================================
  // Idle bus: clock parked high, data released to the pull-up
  initial begin
    scl  = 1'b1;
    pull = 1'b0;
  end

  // Moves only after falling edges of the system clock
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic start();
    // Clock low long enough for the slave to let go of an acknowledge first
    pull = 1'b0;
    tick(3);
    scl = 1'b1;
    tick(2);
    pull = 1'b1;
    tick(2);
    scl = 1'b0;
    tick(1);
  endtask

  task automatic stop();
    pull = 1'b1;
    tick(1);
    scl = 1'b1;
    tick(2);
    pull = 1'b0;
    tick(2);
  endtask

  task automatic xfer_bit(input logic b, output logic r);
    pull = !b;
    tick(3);
    scl = 1'b1;
    tick(2);
    r = sda; // Sampled mid-high, well after the slave output settles
    tick(2);
    scl = 1'b0;
    tick(1);
  endtask

  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(b[i], r);
    end
    xfer_bit(1'b1, r);
    ack = !r;
  endtask

  task automatic rd_byte(input logic more, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(1'b1, r);
      b[i] = r;
    end
    xfer_bit(!more, r);
  endtask
endmodule // tws_mst

// File: tb.sv
// Self-checking bench for the two-wire memory slave
`timescale 1ns/1ns
module tb;
  import tws_pkg::*;
  // ==========================================================
  // Settings: short programming time keeps the run brief
  localparam int         WC  = 200;
  localparam logic [3:0] DT  = 4'h6; // Arbitrary type value
  localparam logic [2:0] SEL = 3'h5;
  logic       clock;
  logic       rst;
  logic       wp;
  logic [2:0] sel;
  logic       scl;
  logic       pull;
  logic       sda;
  logic       sda_o;
  logic       sda_oe;
  logic       write_busy;
  logic [7:0] rq[$];
  int         n_fail;
  int         n_tests;

  tws_top #(.WRITE_CYCLES(WC), .DEV_TYPE(DT)) dut (
    .CLOCK(clock), .RST(rst), .SCL(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe),
    .CHIP_SELECT_BIT0_PIN(sel[0]), .CHIP_SELECT_BIT1_PIN(sel[1]),
    .CHIP_SELECT_BIT2_PIN(sel[2]), .WP(wp), .WRITE_BUSY(write_busy));
  tws_mst m (.clk(clock), .sda(sda), .scl(scl), .pull(pull));

  // Open-drain wire with pull-up: low while either party pulls
  assign sda = !((sda_oe && !sda_o) || pull);

  // 20 MHz system clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // ==========================================================
  // Checking and closing
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ==========================================================
  // Frame helpers
  task automatic open_dev(input logic [3:0] t, input logic [2:0] s, input logic rw,
                          output logic ack);
    m.start();
    m.wr_byte({t, s, rw}, ack);
  endtask

  task automatic wr_frame(input logic [15:0] a, input logic [7:0] d[$]);
    logic ack;
    d.push_front(a[7:0]);
    d.push_front(a[15:8]);
    open_dev(DT, SEL, 1'b0, ack);
    check(8'(ack), 8'h01);
    foreach (d[i]) begin
      m.wr_byte(d[i], ack);
      check(8'(ack), 8'h01);
    end
    m.stop();
  endtask

  task automatic rd_frame(input logic [15:0] a, input int n, output logic [7:0] q[$]);
    logic       ack;
    logic [7:0] b;
    q = {};
    open_dev(DT, SEL, 1'b0, ack);
    m.wr_byte(a[15:8], ack);
    m.wr_byte(a[7:0], ack);
    open_dev(DT, SEL, 1'b1, ack);
    check(8'(ack), 8'h01);
    for (int i = 0; i < n; i++) begin
      m.rd_byte(i < n - 1, b);
      q.push_back(b);
    end
    m.stop();
  endtask

  // Waits out programming; the data line must stay released meanwhile
  task automatic settle(input logic exp_busy);
    int cnt;
    cnt = 0;
    for (int i = 0; i < 10 && write_busy !== 1'b1; i++) begin
      @(negedge clock);
    end
    check(8'(write_busy), 8'(exp_busy));
    while (write_busy === 1'b1 && cnt < 2 * WC) begin
      check(8'(sda_oe), 8'h00);
      cnt++;
      @(negedge clock);
    end
    if (cnt >= 2 * WC) begin
      n_fail++;
      report_and_stop();
    end
    if (exp_busy) begin
      check(8'(cnt >= WC - 2 && cnt <= WC + 2), 8'h01);
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic s_byte();
    wr_frame(16'h0123, {8'h5A});
    settle(1'b1);
    rd_frame(16'h0123, 1, rq);
    check(rq[0], 8'h5A);
    check(8'(sda_o), 8'h00);
  endtask

  // Slave address during programming is refused, then accepted once the cycle ends
  task automatic s_poll();
    logic ack;
    int   n;
    wr_frame(16'h0040, {8'h3C});
    open_dev(DT, SEL, 1'b0, ack);
    check(8'(ack), 8'h00);
    m.stop();
    // Poll until acknowledged; the bound covers the cycle several times over
    n = 0;
    while (!ack && n < 8) begin
      open_dev(DT, SEL, 1'b0, ack);
      m.stop();
      n++;
    end
    check(8'(ack), 8'h01);
    check(8'(write_busy), 8'h00);
    rd_frame(16'h0040, 1, rq);
    check(rq[0], 8'h3C);
  endtask

  // Each select bit and the type field mismatched in turn
  task automatic s_mismatch();
    logic ack;
    for (int i = 0; i < 4; i++) begin
      open_dev(i < 3 ? DT : DT ^ 4'h8, i < 3 ? SEL ^ (3'h1 << i) : SEL, 1'b0, ack);
      check(8'(ack), 8'h00);
      m.stop();
    end
  endtask

  // Full page, read back sequentially with acknowledges
  task automatic s_page();
    logic [7:0] d[$];
    for (int i = 0; i < 32; i++) begin
      d.push_back(8'(i) ^ 8'hA5);
    end
    wr_frame(16'h0100, d);
    settle(1'b1);
    rd_frame(16'h0100, 32, rq);
    foreach (d[i]) begin
      check(rq[i], d[i]);
    end
  endtask

  // Load past the page end with unused high address bits set
  task automatic s_wrap();
    wr_frame(16'hF2FE, {8'h11, 8'h22, 8'h33, 8'h44});
    settle(1'b1);
    rd_frame(16'h02FE, 2, rq);
    check(rq[0], 8'h11);
    check(rq[1], 8'h22);
    rd_frame(16'h02E0, 2, rq);
    check(rq[0], 8'h33);
    check(rq[1], 8'h44);
  endtask

  task automatic s_protect();
    wr_frame(16'h0C10, {8'h77});
    settle(1'b1);
    wp = 1'b1;
    wr_frame(16'h0C10, {8'h88});
    settle(1'b0);
    wr_frame(16'h0810, {8'h99});
    settle(1'b1);
    rd_frame(16'h0C10, 1, rq);
    check(rq[0], 8'h77);
    rd_frame(16'h0810, 1, rq);
    check(rq[0], 8'h99);
    wp = 1'b0;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    wp = 1'b0;
    sel = SEL;
    n_fail = 0;
    n_tests = 0;
    repeat (20) @(negedge clock);
    rst = 1'b0;
    repeat (5) @(negedge clock);
    s_byte();
    s_poll();
    s_mismatch();
    s_page();
    s_wrap();
    s_protect();
    report_and_stop();
  end

  // Cuts a hang short
  initial begin
    repeat (100000) @(posedge clock);
    n_fail++;
    report_and_stop();
  end
endmodule // tb
